// ### src/app_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module app_ctrl #(
  parameter int unsigned PD_WAKE_CYC = app_pkg::PD_WAKE_CYC
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // converter core
  input  wire logic        samp_clk_i,
  input  wire logic [13:0] raw_data_i,
  input  wire logic        raw_ovr_i,
  // configuration pins
  input  wire logic        out_en_pin_i,
  input  wire logic        par_cfg_i,
  input  wire logic [1:0]  format_interface_pin_i,
  input  wire logic        variant_12b_i,
  // sample output
  output logic      [13:0] data_o,
  output logic             data_oe_o,
  output logic             data_valid_o,
  output logic             ovr_o,
  output logic             iface_cmos_o,
  // power state
  output logic             core_sleep_o,
  output logic             ref_off_o,
  output logic             low_power_o
);
  localparam int unsigned LAT = app_pkg::LL_LAT;
  localparam logic [14:0] PD_WAKE_LD = 15'(PD_WAKE_CYC);
  localparam logic [14:0] SB_WAKE_LD = 15'(app_pkg::SB_WAKE_CYC);
  localparam logic [14:0] OB_WAKE_LD = 15'(app_pkg::OBUF_WAKE_CYC);
  localparam logic [7:0]  SLOW_LIM   = 8'(app_pkg::SLOW_WIN_CYC);
  localparam logic signed [47:0] OFS_LIM = 48'(app_pkg::OFS_LIMIT_CODES);
  localparam logic signed [7:0]  EST_LIM = 8'(app_pkg::OFS_LIMIT_CODES);

  // configuration registers
  logic              bypass_path_off_q;
  logic              dc_loop_on_q;
  logic              dc_loop_hold_q;
  logic              fmt_ob_q;
  logic              cmos_q;
  logic [3:0]        gain_q;
  logic [3:0]        tc_q;
  logic              full_chip_powerdown_q;
  logic              core_sleep_q;
  logic              output_buffer_off_q;
  logic              srst_q;
  logic              ack_q;
  logic [31:0]       rdat_q;
  // state
  logic              samp_prev_q;
  logic              pd_prev_q;
  logic              sleep_prev_q;
  logic              buf_prev_q;
  logic [14:0]       wake_q;
  logic [7:0]        slow_cnt_q;
  logic              low_power_q;
  logic signed [13:0] pd_q [LAT];
  logic              pv_q [LAT];
  logic              po_q [LAT];
  logic signed [47:0] acc_q;
  logic signed [14:0] s1_q;
  logic              s1_v_q;
  logic              s1_o_q;
  logic signed [17:0] s2_q;
  logic              s2_v_q;
  logic              s2_o_q;
  logic [13:0]       data_q;
  logic              valid_q;
  logic              ovr_q;

  // bus decode
  wire wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_lane0 = wb_req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl  = wr_lane0 & (wb_adr_i == app_pkg::CTRL_OFS);
  wire wr_gain  = wr_lane0 & (wb_adr_i == app_pkg::GAIN_OFS);
  wire wr_tc    = wr_lane0 & (wb_adr_i == app_pkg::TC_OFS);
  wire wr_pwr   = wr_lane0 & (wb_adr_i == app_pkg::PWR_OFS);
  wire rd_req   = wb_req & ~wb_we_i;
  wire cfg_clr  = srst_q;

  // sampling edge and effective controls
  wire samp_edge = samp_clk_i & ~samp_prev_q; // RULE_01
  wire dig_on    = bypass_path_off_q; // RULE_04 RULE_20
  wire dc_run    = dig_on & dc_loop_on_q; // RULE_12
  wire tail_v    = pv_q[LAT-1];
  wire tail_o    = po_q[LAT-1];
  wire signed [13:0] tail = pd_q[LAT-1];
  wire dc_upd    = dc_run & ~dc_loop_hold_q & samp_edge & tail_v; // RULE_11
  wire fmt_ob    = par_cfg_i ? format_interface_pin_i[1] : fmt_ob_q; // RULE_17
  wire cmos_sel  = par_cfg_i ? (format_interface_pin_i[1] ^ format_interface_pin_i[0]) : cmos_q; // RULE_03

  // power decode
  wire core_off  = full_chip_powerdown_q | core_sleep_q; // RULE_13 RULE_14
  wire buf_on    = ~full_chip_powerdown_q & ~output_buffer_off_q & out_en_pin_i; // RULE_15
  wire pd_exit   = pd_prev_q & ~full_chip_powerdown_q;
  wire sb_exit   = sleep_prev_q & ~core_sleep_q;
  wire ob_exit   = buf_on & ~buf_prev_q;
  wire [14:0] wake_load = pd_exit ? PD_WAKE_LD : (sb_exit ? SB_WAKE_LD : (ob_exit ? OB_WAKE_LD : 15'h0000));
  wire [14:0] wake_dec  = (wake_q != 15'h0000) ? wake_q - 15'h0001 : 15'h0000;
  wire [14:0] wake_d    = (wake_load > wake_q) ? wake_load : wake_dec;
  wire wake_busy = wake_q != 15'h0000;

  // offset loop estimate
  wire [3:0]  tc_sel   = (tc_q > app_pkg::TC_MAX) ? app_pkg::TC_MAX : tc_q; // RULE_10
  wire [5:0]  tc_shift = app_pkg::TC_BASE_SHIFT + {2'b00, tc_sel}; // RULE_10
  wire signed [47:0] est_full = acc_q >>> tc_shift;
  wire signed [47:0] est_clip = (est_full > OFS_LIM) ? OFS_LIM : ((est_full < -OFS_LIM) ? -OFS_LIM : est_full); // RULE_09
  wire signed [7:0]  est8     = est_clip[7:0];
  wire signed [47:0] acc_d    = acc_q + 48'(tail) - est_full; // RULE_09

  // gain
  wire [3:0]  gain_sel = (gain_q > app_pkg::GAIN_MAX) ? app_pkg::GAIN_MAX : gain_q; // RULE_08
  wire [13:0] gain_fac = app_pkg::GAIN_TAB[gain_sel]; // RULE_07 RULE_08
  wire signed [29:0] prod = s1_q * $signed({1'b0, gain_fac});
  wire signed [14:0] s1_d = 15'(tail) - (dc_run ? 15'(est8) : 15'sh0000); // RULE_09

  // output selection, saturation and format
  wire signed [17:0] sel_val = dig_on ? s2_q : 18'(tail); // RULE_04 RULE_05
  wire sel_v   = dig_on ? s2_v_q : tail_v;
  wire sel_o   = dig_on ? s2_o_q : tail_o;
  wire sat_pos = sel_o ? ~sel_val[17] : (sel_val > 18'sh01fff); // RULE_18
  wire sat_neg = sel_o ? sel_val[17] : (sel_val < -18'sh02000); // RULE_18
  wire [13:0] sat_w = sat_pos ? 14'h1fff : (sat_neg ? 14'h2000 : sel_val[13:0]); // RULE_18
  wire [13:0] fmt_w = fmt_ob ? {~sat_w[13], sat_w[12:0]} : sat_w; // RULE_17
  wire [13:0] out_w = variant_12b_i ? {2'b00, fmt_w[13:2]} : fmt_w; // RULE_03

  // read mux
  wire [31:0] rd_ctrl = {27'h0, cmos_q, fmt_ob_q, dc_loop_hold_q, dc_loop_on_q, bypass_path_off_q};
  wire [31:0] rd_pwr  = {29'h0, output_buffer_off_q, core_sleep_q, full_chip_powerdown_q};
  wire [31:0] rd_stat = {28'h0, wake_busy, ~dig_on, low_power_q, valid_q};
  wire [31:0] rd_mux  = (wb_adr_i == app_pkg::CTRL_OFS) ? rd_ctrl :
                        (wb_adr_i == app_pkg::GAIN_OFS) ? {28'h0, gain_q} :
                        (wb_adr_i == app_pkg::TC_OFS)   ? {28'h0, tc_q} :
                        (wb_adr_i == app_pkg::PWR_OFS)  ? rd_pwr :
                        (wb_adr_i == app_pkg::STAT_OFS) ? rd_stat :
                        (wb_adr_i == app_pkg::EST_OFS)  ? 32'(est8) : 32'h0000_0000;

  // bus handshake
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      srst_q <= 1'b0;
    end else begin
      ack_q  <= wb_req;
      rdat_q <= rd_req ? rd_mux : rdat_q;
      srst_q <= wr_ctrl & wb_dat_i[app_pkg::CTRL_SRST_BIT]; // RULE_19
    end
  end

  // control register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin // RULE_06 RULE_12
      {cmos_q, fmt_ob_q, dc_loop_hold_q, dc_loop_on_q, bypass_path_off_q} <= app_pkg::CTRL_RST;
    end else if (cfg_clr) begin // RULE_19
      {cmos_q, fmt_ob_q, dc_loop_hold_q, dc_loop_on_q, bypass_path_off_q} <= app_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      bypass_path_off_q <= wb_dat_i[app_pkg::CTRL_BYP_OFF_BIT];
      dc_loop_on_q      <= wb_dat_i[app_pkg::CTRL_DC_ON_BIT];
      dc_loop_hold_q    <= wb_dat_i[app_pkg::CTRL_DC_HOLD_BIT];
      fmt_ob_q          <= wb_dat_i[app_pkg::CTRL_FMT_OB_BIT];
      cmos_q            <= wb_dat_i[app_pkg::CTRL_CMOS_BIT];
    end
  end

  // gain, time constant and power registers, kept while bypassed
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_q <= app_pkg::GAIN_RST; // RULE_07
      tc_q   <= app_pkg::TC_RST;
      {output_buffer_off_q, core_sleep_q, full_chip_powerdown_q} <= app_pkg::PWR_RST;
    end else if (cfg_clr) begin // RULE_19
      gain_q <= app_pkg::GAIN_RST;
      tc_q   <= app_pkg::TC_RST;
      {output_buffer_off_q, core_sleep_q, full_chip_powerdown_q} <= app_pkg::PWR_RST;
    end else begin
      gain_q <= wr_gain ? wb_dat_i[3:0] : gain_q; // RULE_20
      tc_q   <= wr_tc ? wb_dat_i[3:0] : tc_q; // RULE_20
      if (wr_pwr) begin
        full_chip_powerdown_q <= wb_dat_i[app_pkg::PWR_FULL_BIT]; // RULE_13
        core_sleep_q          <= wb_dat_i[app_pkg::PWR_SLEEP_BIT]; // RULE_14
        output_buffer_off_q   <= wb_dat_i[app_pkg::PWR_OBUF_BIT]; // RULE_15
      end
    end
  end

  // power state and wake timer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_prev_q    <= 1'b0;
      sleep_prev_q <= 1'b0;
      buf_prev_q   <= 1'b1; // no false buffer wake after reset
      wake_q       <= 15'h0000;
    end else begin
      pd_prev_q    <= full_chip_powerdown_q;
      sleep_prev_q <= core_sleep_q;
      buf_prev_q   <= buf_on;
      wake_q       <= wake_d; // RULE_13 RULE_14 RULE_15
    end
  end

  // slow sampling clock detector
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_prev_q <= 1'b0;
      slow_cnt_q  <= 8'h00;
      low_power_q <= 1'b0;
    end else begin
      samp_prev_q <= samp_clk_i;
      slow_cnt_q  <= samp_edge ? 8'h00 : ((slow_cnt_q == SLOW_LIM) ? slow_cnt_q : slow_cnt_q + 8'h01); // RULE_16
      low_power_q <= samp_edge ? 1'b0 : (low_power_q | (slow_cnt_q == SLOW_LIM)); // RULE_16
    end
  end

  // converter pipeline, one stage per sampling edge
  for (genvar g = 0; g < LAT; g++) begin : g_pipe
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        pd_q[g] <= 14'sh0000;
        pv_q[g] <= 1'b0;
        po_q[g] <= 1'b0;
      end else if (samp_edge) begin // RULE_02
        pd_q[g] <= (g == 0) ? $signed(raw_data_i) : pd_q[(g == 0) ? 0 : g - 1]; // RULE_01
        pv_q[g] <= (g == 0) ? ~core_off : pv_q[(g == 0) ? 0 : g - 1];
        po_q[g] <= (g == 0) ? raw_ovr_i : po_q[(g == 0) ? 0 : g - 1];
      end
    end
  end

  // offset accumulator
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 48'sh0;
    end else if (!dc_run) begin
      acc_q <= 48'sh0; // RULE_12
    end else if (dc_upd) begin
      acc_q <= acc_d; // RULE_09 RULE_10
    end
  end

  // digital stages: offset subtract, then gain
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q   <= 15'sh0000;
      s1_v_q <= 1'b0;
      s1_o_q <= 1'b0;
      s2_q   <= 18'sh00000;
      s2_v_q <= 1'b0;
      s2_o_q <= 1'b0;
    end else if (samp_edge) begin // RULE_05
      s1_q   <= s1_d;
      s1_v_q <= tail_v;
      s1_o_q <= tail_o;
      s2_q   <= 18'(prod >>> app_pkg::GAIN_FRAC); // RULE_08
      s2_v_q <= s1_v_q;
      s2_o_q <= s1_o_q;
    end
  end

  // output word register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_q  <= 14'h0000;
      valid_q <= 1'b0;
      ovr_q   <= 1'b0;
    end else if (samp_edge) begin // RULE_02
      data_q  <= out_w;
      valid_q <= sel_v;
      ovr_q   <= sel_o | sat_pos | sat_neg;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;
  assign data_o       = data_q;
  assign data_oe_o    = buf_on; // RULE_13 RULE_15
  assign data_valid_o = valid_q & buf_on & ~wake_busy & ~core_off;
  assign ovr_o        = ovr_q;
  assign iface_cmos_o = cmos_sel;
  assign core_sleep_o = core_off; // RULE_14
  assign ref_off_o    = full_chip_powerdown_q; // RULE_13
  assign low_power_o  = low_power_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_capture;
    samp_edge |=> (pd_q[0] == $signed($past(raw_data_i))) && (pv_q[0] == $past(~core_off));
  endproperty
  a_capture: assert property (p_capture) else $error("sample not captured on edge"); // RULE_01

  property p_hold;
    !samp_edge |=> $stable(data_q) && $stable(pd_q[LAT-1]);
  endproperty
  a_hold: assert property (p_hold) else $error("pipeline moved without edge"); // RULE_02

  property p_bypass;
    (samp_edge && !dig_on && !tail_o && !fmt_ob && !variant_12b_i) |=> data_q == $past(tail);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass word altered"); // RULE_04

  property p_gain0;
    (samp_edge && dig_on && gain_q == 4'h0) |=> s2_q == 18'($past(s1_q));
  endproperty
  a_gain0: assert property (p_gain0) else $error("0 dB gain changed sample"); // RULE_07

  property p_est_limit;
    (est8 <= EST_LIM) && (est8 >= -EST_LIM);
  endproperty
  a_est_limit: assert property (p_est_limit) else $error("offset estimate over limit"); // RULE_09

  property p_freeze;
    (dc_run && dc_loop_hold_q) |=> $stable(acc_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("held loop still updating"); // RULE_11

  property p_dc_off;
    !dc_run |=> acc_q == 48'sh0;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("offset loop active while off"); // RULE_12

  property p_pd_tristate;
    full_chip_powerdown_q |-> !data_oe_o && !data_valid_o && ref_off_o;
  endproperty
  a_pd_tristate: assert property (p_pd_tristate) else $error("outputs driven in powerdown"); // RULE_13

  property p_pd_wake;
    pd_exit |=> (wake_q == PD_WAKE_LD) ##1 (wake_q == PD_WAKE_LD - 15'h0001);
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("powerdown wake time wrong"); // RULE_13

  property p_obuf;
    (output_buffer_off_q || !out_en_pin_i) |-> !data_oe_o;
  endproperty
  a_obuf: assert property (p_obuf) else $error("buffer driven while disabled"); // RULE_15

  property p_ob_wake;
    (ob_exit && !pd_exit && !sb_exit && wake_q < OB_WAKE_LD) |=> wake_q == OB_WAKE_LD;
  endproperty
  a_ob_wake: assert property (p_ob_wake) else $error("buffer wake time wrong"); // RULE_15

  property p_sb_wake;
    (sb_exit && !pd_exit && wake_q < SB_WAKE_LD) |=> wake_q == SB_WAKE_LD;
  endproperty
  a_sb_wake: assert property (p_sb_wake) else $error("standby wake time wrong"); // RULE_14

  property p_sleep;
    (core_sleep_q && !full_chip_powerdown_q) |-> core_sleep_o && !ref_off_o && !data_valid_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby state wrong"); // RULE_14

  property p_slow;
    (slow_cnt_q == SLOW_LIM && !samp_edge) |=> low_power_o;
  endproperty
  a_slow: assert property (p_slow) else $error("slow clock not detected"); // RULE_16

  property p_sat;
    (samp_edge && !dig_on && tail_o && !tail[13] && !fmt_ob && !variant_12b_i) |=> data_q == 14'h1fff && ovr_o;
  endproperty
  a_sat: assert property (p_sat) else $error("overdrive not saturated"); // RULE_18

  property p_srst;
    (wr_ctrl && wb_dat_i[app_pkg::CTRL_SRST_BIT]) |=> srst_q ##1 (!srst_q && !bypass_path_off_q && gain_q == 4'h0);
  endproperty
  a_srst: assert property (p_srst) else $error("software reset failed"); // RULE_19
endmodule
`default_nettype wire

// ### shared/app_pkg.sv
// Function
// RULE_01: sample taken on sampling clock rising edge
// RULE_02: ten sampling edges from capture to output
// RULE_03: 14-bit word, or 12-bit variant, two interfaces
// RULE_04: bypass path: raw data, ten edges latency
// RULE_05: digital functions add extra pipeline latency
// RULE_06: reset into bypass; software clears it first
// RULE_07: leaving bypass enables gain at 0 dB
// RULE_08: gain 0 to 6 dB, half-dB steps
// RULE_09: offset loop subtracts estimate, limit 10 mV
// RULE_10: time constant 2^20 to 2^31, codes reserved
// RULE_11: hold freezes estimate, keeps applying it
// RULE_12: offset loop off after reset; enable after bypass
// RULE_13: full powerdown tristates outputs, 100 us wake
// RULE_14: core sleep keeps references, 5 us wake
// RULE_15: buffer off or pin low tristates, 100 ns
// RULE_16: slow sampling clock enters low power mode
// RULE_17: twos complement or offset binary, register or pin
// RULE_18: overdrive saturates to matching full scale
// RULE_19: software reset bit restores defaults, self-clears
// RULE_20: settings kept in bypass, applied when enabled
`default_nettype none
package app_pkg;
  localparam int unsigned SAMPLE_W  = 14;
  localparam int unsigned LL_LAT    = 10;
  localparam int unsigned DIG_EXTRA = 2;
  localparam int unsigned ACC_W     = 48;
  localparam int unsigned WAKE_W    = 15;
  localparam int unsigned SLOW_W    = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GAIN_OFS = 8'h04;
  localparam logic [7:0] TC_OFS   = 8'h08;
  localparam logic [7:0] PWR_OFS  = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] EST_OFS  = 8'h14;
  // field positions
  localparam int unsigned CTRL_BYP_OFF_BIT = 0;
  localparam int unsigned CTRL_DC_ON_BIT   = 1;
  localparam int unsigned CTRL_DC_HOLD_BIT = 2;
  localparam int unsigned CTRL_FMT_OB_BIT  = 3;
  localparam int unsigned CTRL_CMOS_BIT    = 4;
  localparam int unsigned CTRL_SRST_BIT    = 7;
  localparam int unsigned PWR_FULL_BIT     = 0;
  localparam int unsigned PWR_SLEEP_BIT    = 1;
  localparam int unsigned PWR_OBUF_BIT     = 2;
  // values after reset
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [3:0] GAIN_RST = 4'h0;
  localparam logic [3:0] TC_RST   = 4'h0;
  localparam logic [2:0] PWR_RST  = 3'h0;
  // gain and offset loop
  localparam logic [3:0]  GAIN_MAX      = 4'hc;
  localparam int unsigned GAIN_FRAC     = 12;
  localparam logic [13:0] GAIN_TAB [13] = '{14'd4096, 14'd4339, 14'd4596, 14'd4868, 14'd5157, 14'd5462,
                                            14'd5786, 14'd6129, 14'd6492, 14'd6877, 14'd7284, 14'd7715, 14'd8173};
  localparam logic [3:0]  TC_MAX        = 4'hb;
  localparam logic [5:0]  TC_BASE_SHIFT = 6'd20;
  localparam int unsigned OFS_LIMIT_MV  = 10;
  localparam int unsigned FS_MVPP       = 2000;
  localparam int unsigned OFS_LIMIT_CODES = OFS_LIMIT_MV * (1 << SAMPLE_W) / FS_MVPP;
  // timing
  localparam int unsigned CLK_FREQ_MHZ    = 200;
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned PD_WAKE_US      = 100;
  localparam int unsigned PD_WAKE_CYC     = PD_WAKE_US * CLK_FREQ_MHZ;
  localparam int unsigned SB_WAKE_US      = 5;
  localparam int unsigned SB_WAKE_CYC     = SB_WAKE_US * CLK_FREQ_MHZ;
  localparam int unsigned OBUF_WAKE_NS    = 100;
  localparam int unsigned OBUF_WAKE_CYC   = OBUF_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_RATE_WIN_NS = 1000;
  localparam int unsigned SLOW_WIN_CYC    = MIN_RATE_WIN_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### verif/app_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module app_rx_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // sample stream
  input  wire logic        samp_clk_i,
  input  wire logic [13:0] data_i,
  input  wire logic        valid_i,
  input  wire logic        oe_i,
  // captured word
  output logic      [13:0] word_o
);
  logic samp_q;
  logic seen_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_q <= 1'b0;
      seen_q <= 1'b0;
      word_o <= 14'h0000;
    end else begin
      samp_q <= samp_clk_i;
      seen_q <= samp_clk_i & ~samp_q;
      // takes a word one cycle after each sampling edge, only while driven and valid
      if (seen_q && valid_i && oe_i) begin
        word_o <= data_i;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/test_app_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_app_ctrl;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [3:0]  gain;
    logic        v12;
    logic [13:0] raw;
    logic        ovr;
    logic [13:0] exp_word;
    logic        exp_ovr;
  } app_row_s;
  localparam app_row_s ROWS [13] = '{
    '{8'h00, 4'h0, 1'b0, 14'h0123, 1'b0, 14'h0123, 1'b0},
    '{8'h08, 4'h0, 1'b0, 14'h0123, 1'b0, 14'h2123, 1'b0},
    '{8'h00, 4'h0, 1'b1, 14'h1234, 1'b0, 14'h048d, 1'b0},
    '{8'h00, 4'h0, 1'b0, 14'h0100, 1'b1, 14'h1fff, 1'b1},
    '{8'h00, 4'h0, 1'b0, 14'h3f00, 1'b1, 14'h2000, 1'b1},
    '{8'h08, 4'h0, 1'b0, 14'h3f00, 1'b1, 14'h0000, 1'b1},
    '{8'h01, 4'h0, 1'b0, 14'h0123, 1'b0, 14'h0123, 1'b0},
    '{8'h00, 4'hc, 1'b0, 14'h1000, 1'b0, 14'h1000, 1'b0},
    '{8'h01, 4'hc, 1'b0, 14'h1000, 1'b0, 14'h1fed, 1'b0},
    '{8'h01, 4'h2, 1'b0, 14'h1000, 1'b0, 14'h11f4, 1'b0},
    '{8'h01, 4'hf, 1'b0, 14'h1000, 1'b0, 14'h1fed, 1'b0},
    '{8'h01, 4'hc, 1'b0, 14'h1800, 1'b0, 14'h1fff, 1'b1},
    '{8'h01, 4'h0, 1'b1, 14'h1000, 1'b0, 14'h0400, 1'b0}
  };
  logic        core_clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_dat, rd;
  logic        samp, raw_ovr, oe_pin, par_cfg, v12;
  logic [13:0] raw, data_o, rx_word;
  logic [1:0]  fmt_pin;
  logic        data_oe_o, data_valid_o, ovr_o, iface_cmos_o, core_sleep_o, ref_off_o, low_power_o;
  int          err_count, compares, lat;
  app_row_s    row;

  app_ctrl #(.PD_WAKE_CYC(50)) uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .samp_clk_i(samp), .raw_data_i(raw), .raw_ovr_i(raw_ovr),
    .out_en_pin_i(oe_pin), .par_cfg_i(par_cfg), .format_interface_pin_i(fmt_pin), .variant_12b_i(v12),
    .data_o(data_o), .data_oe_o(data_oe_o), .data_valid_o(data_valid_o), .ovr_o(ovr_o),
    .iface_cmos_o(iface_cmos_o), .core_sleep_o(core_sleep_o), .ref_off_o(ref_off_o),
    .low_power_o(low_power_o)
  );
  app_rx_model rx (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .samp_clk_i(samp), .data_i(data_o),
    .valid_i(data_valid_o), .oe_i(data_oe_o), .word_o(rx_word)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk14(input string nm, input logic [13:0] e, input logic [13:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // classic single cycle: hold until ack is sampled high, then release
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge core_clk_i);
    end while (wb_ack !== 1'b1);
    r = wb_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
  endtask
  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask
  task automatic wb_read(input logic [7:0] a, output logic [31:0] r);
    wb_xfer(1'b0, a, 32'h0, r);
  endtask

  // one sampling edge, three core cycles apart
  task automatic samp_edge(input logic [13:0] w, input logic o);
    @(posedge core_clk_i);
    samp <= 1'b1;
    raw <= w;
    raw_ovr <= o;
    @(posedge core_clk_i);
    samp <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic run_word(input logic [13:0] w, input logic o, input int n, input logic [13:0] e, input logic eo);
    samp_edge(w, o);
    repeat (n - 1) samp_edge(14'h0000, 1'b0);
    chk1("not_early", 1'b1, rx_word !== e);
    samp_edge(14'h0000, 1'b0);
    chk14("word", e, rx_word);
    chk1("ovr", eo, ovr_o);
  endtask
  task automatic check_defaults();
    logic [31:0] r;
    wb_read(app_pkg::CTRL_OFS, r);
    chk32("ctrl", 32'h0, r);
    wb_read(app_pkg::GAIN_OFS, r);
    chk32("gain", 32'h0, r);
    wb_read(app_pkg::TC_OFS, r);
    chk32("tc", 32'h0, r);
    wb_read(app_pkg::PWR_OFS, r);
    chk32("pwr", 32'h0, r);
    wb_read(app_pkg::EST_OFS, r);
    chk32("est", 32'h0, r);
    wb_read(app_pkg::STAT_OFS, r);
    chk32("stat_bypass", 32'h4, r & 32'h4);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    err_count = 0;
    compares = 0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, samp, raw_ovr, par_cfg, v12} = '0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    raw = 14'h0000;
    fmt_pin = 2'h0;
    oe_pin = 1'b1;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    check_defaults();
    foreach (ROWS[i]) begin
      row = ROWS[i];
      wb_write(app_pkg::CTRL_OFS, {24'h0, row.ctrl});
      wb_write(app_pkg::GAIN_OFS, {28'h0, row.gain});
      @(posedge core_clk_i);
      v12 <= row.v12;
      lat = row.ctrl[0] ? 12 : 10;
      run_word(row.raw, row.ovr, lat, row.exp_word, row.exp_ovr);
    end
    wb_write(app_pkg::CTRL_OFS, 32'h0);
    @(posedge core_clk_i);
    v12 <= 1'b0;
    par_cfg <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_i);
      fmt_pin <= 2'(k);
      @(posedge core_clk_i);
      #1;
      chk1("iface_cmos", 1'(k) ^ 1'(k >> 1), iface_cmos_o);
    end
    run_word(14'h0123, 1'b0, 10, 14'h2123, 1'b0);
    @(posedge core_clk_i);
    par_cfg <= 1'b0;
    wb_write(app_pkg::CTRL_OFS, 32'h1);
    wb_write(app_pkg::CTRL_OFS, 32'h3);
    repeat (200) samp_edge(14'h1fff, 1'b0);
    wb_read(app_pkg::EST_OFS, rd);
    chk32("est_run", 32'h1, rd);
    wb_write(app_pkg::CTRL_OFS, 32'h7);
    run_word(14'h0100, 1'b0, 12, 14'h00ff, 1'b0);
    wb_read(app_pkg::EST_OFS, rd);
    chk32("est_hold", 32'h1, rd);
    wb_write(app_pkg::TC_OFS, 32'hb);
    wb_read(app_pkg::TC_OFS, rd);
    chk32("tc_set", 32'hb, rd);
    wb_read(app_pkg::CTRL_OFS, rd);
    chk32("ctrl_set", 32'h7, rd);
    wb_write(app_pkg::CTRL_OFS, 32'h80);
    repeat (2) @(posedge core_clk_i);
    check_defaults();
    wb_write(8'h40, 32'hff);
    wb_read(8'h40, rd);
    chk32("unmapped", 32'h0, rd);
    // full powerdown, then wake timer
    wb_write(app_pkg::PWR_OFS, 32'h1);
    @(posedge core_clk_i);
    #1;
    chk1("oe_full", 1'b0, data_oe_o);
    chk1("sleep_full", 1'b1, core_sleep_o);
    chk1("ref_full", 1'b1, ref_off_o);
    wb_write(app_pkg::PWR_OFS, 32'h0);
    repeat (10) samp_edge(14'h0000, 1'b0);
    chk1("valid_pd_wake", 1'b0, data_valid_o);
    repeat (20) samp_edge(14'h0000, 1'b0);
    chk1("valid_pd_done", 1'b1, data_valid_o);
    // standby keeps references
    wb_write(app_pkg::PWR_OFS, 32'h2);
    @(posedge core_clk_i);
    #1;
    chk1("sleep_sb", 1'b1, core_sleep_o);
    chk1("ref_sb", 1'b0, ref_off_o);
    chk1("oe_sb", 1'b1, data_oe_o);
    wb_write(app_pkg::PWR_OFS, 32'h0);
    repeat (10) samp_edge(14'h0000, 1'b0);
    chk1("valid_sb_wake", 1'b0, data_valid_o);
    repeat (350) samp_edge(14'h0000, 1'b0);
    chk1("valid_sb_done", 1'b1, data_valid_o);
    // buffer off by bit and by pin
    wb_write(app_pkg::PWR_OFS, 32'h4);
    @(posedge core_clk_i);
    #1;
    chk1("oe_bit", 1'b0, data_oe_o);
    wb_write(app_pkg::PWR_OFS, 32'h0);
    oe_pin <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk1("oe_pin", 1'b0, data_oe_o);
    @(posedge core_clk_i);
    oe_pin <= 1'b1;
    // stopped sampling clock
    repeat (190) @(posedge core_clk_i);
    #1;
    chk1("lp_early", 1'b0, low_power_o);
    repeat (20) @(posedge core_clk_i);
    #1;
    chk1("lp_set", 1'b1, low_power_o);
    samp_edge(14'h0000, 1'b0);
    chk1("lp_clear", 1'b0, low_power_o);
    wrap_up();
  end
endmodule
`default_nettype wire
